// [rtl/adc_consts.svh]
// Purpose: constants for the serial command end and host end of the converter link
// Assumes: one 50 MHz clock, link pins sampled as synchronous inputs
// Notes: all offsets, fields and counts live here as macros
// Notes on behaviour
// - bit 7 set: pseudo-differential, minus channel lost
// - sixteen-bit words, msb first, command nibble on top
// - config read returns config in low twelve bits
// - conversion and fifo reads put result high
// - bit 10 picks straight binary or two's complement
// - frame high at select fall: rise capture
// - frame falling edge starts: fall capture
// - host writes a000h first after power-up
// - codes 0-7 pick channels, four-input takes evens
// - code 1000b powers down analog and reference
// - code 1010b loads twelve data bits into config
// - codes b, c, d pick internal test voltages
// - config survives hardware and software power-down
// - clock may pause mid-word during config write
// - host reads config only in one-shot mode
// - bit 11 picks internal or external reference
// - bit 9 picks 12 or 24 clock sampling
// - bit 8 picks serial clock or half of it
// - mode field picks one of four conversion modes
// - sweep order field only acts in sweep modes
// - bit 2 picks interrupt or end-of-conversion pin
// - trigger field sets fifo level 7, 5, 3, 1
// - output released while deselected and after sixteen bits
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

`define WORD_BITS       5'd16
`define CMD_DONE_BITS   5'd4
`define RESULT_LSB      6
`define CMD_PWDN        4'h8
`define CMD_RD_CFG      4'h9
`define CMD_WR_CFG      4'ha
`define CMD_TEST_MID    4'hb
`define CMD_TEST_LOW    4'hc
`define CMD_TEST_HIGH   4'hd
`define CMD_FIFO_RD     4'he
`define CMD_RSVD        4'hf
`define INIT_WORD       16'ha000
`define CFG_RESET       12'h000
`define CFG_REF_BIT     11
`define CFG_CODE_BIT    10
`define CFG_SAMP_BIT    9
`define CFG_CDIV_BIT    8
`define CFG_PDIFF_BIT   7
`define CFG_MODE_HI     6
`define CFG_MODE_LO     5
`define CFG_SEQ_HI      4
`define CFG_SEQ_LO      3
`define CFG_PIN_BIT     2
`define CFG_TRIG_HI     1
`define CFG_TRIG_LO     0
`define MODE_ONE_SHOT   2'b00
`define SAMPLE_SHORT    5'd12
`define SAMPLE_LONG     5'd24
`define MINUS_CH8       3'd2
`define MINUS_CH4       3'd1
`define CLK_PERIOD_NS   20
`define SCLK_PERIOD_NS  160
`define SCLK_HALF_CYCLES ((`SCLK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/adc_pkg.sv]
// Purpose: shared types of the converter link
// Assumes: constants come from adc_consts.svh
// Notes: types only
package adc_pkg;
  // what the input multiplexer is told to look at
  typedef enum logic [1:0] {SEL_CHANNEL, SEL_TEST_MID, SEL_TEST_LOW, SEL_TEST_HIGH} analog_sel_e;
endpackage

// [rtl/adc_link_if.sv]
// Purpose: serial pins between host end and converter end
// Assumes: serial output idles high through a pull-up when released
// Notes: sdo_line is the resolved wire the host sees
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic frame_start_strobe;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // released output reads as the pull-up level
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (input cs_n, input sclk, input sdi, input frame_start_strobe,
               output sdo, output sdo_oe);
  modport host (output cs_n, output sclk, output sdi, output frame_start_strobe,
                input sdo_line);
endinterface

// [rtl/adc_cmd_device.sv]
// Purpose: command decoder and configuration word of the converter end
// Assumes: link pins synchronous to clk, serial clock well below clk/2
// Notes: analog side sees decoded fields and one-cycle strobes only
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_cmd_device
  import adc_pkg::*;
#(
  parameter bit EIGHT_INPUTS = 1'b1
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial link
  adc_link_if.dev          link,
  // converter results
  input  wire logic [9:0]  raw_result,
  input  wire logic        raw_valid,
  // configuration view
  output logic      [11:0] configuration_word,
  output logic             ref_internal,
  output logic             twos_comp,
  output logic      [4:0]  sample_clocks,
  output logic             pseudo_diff,
  output logic      [1:0]  conv_mode,
  output logic      [1:0]  sweep_seq,
  output logic             sweep_enable,
  output logic             status_is_eoc,
  output logic      [2:0]  fifo_level,
  // conversion control
  output logic             conv_start,
  output analog_sel_e      analog_sel,
  output logic      [2:0]  channel,
  output logic             conv_tick,
  output logic             sw_power_down,
  output logic             fifo_read,
  output logic      [3:0]  command_nibble
);

  // channel map: {valid, channel}
  function automatic logic [3:0] chan_map(input logic [3:0] c, input logic pd);
    logic [2:0] ch;
    logic       ok;
    ch = 3'd0;
    ok = 1'b0;
    if (EIGHT_INPUTS)
    begin
      ch = c[2:0];
      ok = ~(pd && (ch == `MINUS_CH8));
    end
    else
    begin
      ch = {1'b0, c[2:1]};
      ok = ~c[0] & ~(pd && (ch == `MINUS_CH4));
    end
    return {ok, ch};
  endfunction

  // result coding, two's complement is the msb inverted
  function automatic logic [9:0] code_result(input logic [9:0] r, input logic tc);
    return tc ? {~r[9], r[8:0]} : r;
  endfunction

  // trigger field to fifo fill level
  function automatic logic [2:0] trig_level(input logic [1:0] t);
    logic [2:0] lv;
    lv = 3'd7;
    unique case (t)
      2'b00: lv = 3'd7;
      2'b01: lv = 3'd5;
      2'b10: lv = 3'd3;
      2'b11: lv = 3'd1;
    endcase
    return lv;
  endfunction

  logic        sclk_q;
  logic        cs_q;
  logic        fs_q;
  logic        active_reg;
  logic        fs_mode_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] out_word_reg;
  logic [9:0]  result_reg;
  logic [11:0] cfg_reg;
  logic [3:0]  cmd_reg;
  logic        div_ph_reg;

  // pin edges, previous sample against current
  wire sclk_rise = ~sclk_q & link.sclk;
  wire sclk_fall = sclk_q & ~link.sclk;
  wire cs_fall   = cs_q & ~link.cs_n;
  wire fs_fall   = fs_q & ~link.frame_start_strobe;
  wire start_spi = cs_fall & link.frame_start_strobe;
  wire start_fs  = fs_fall & ~link.cs_n;
  wire start     = start_spi | start_fs;

  // capture and launch edges swap with the framing style
  wire cap_edge  = active_reg & ~link.cs_n & (bit_cnt_reg < `WORD_BITS)
                 & (fs_mode_reg ? sclk_fall : sclk_rise);
  wire sh_edge   = active_reg & ~link.cs_n & (bit_cnt_reg != 5'd0)
                 & (fs_mode_reg ? sclk_rise : sclk_fall);
  wire [15:0] rx_next  = {rx_reg[14:0], link.sdi};
  wire [4:0]  cnt_next = bit_cnt_reg + 5'd1;
  wire        at_cmd   = cap_edge & (cnt_next == `CMD_DONE_BITS);
  wire        at_end   = cap_edge & (cnt_next == `WORD_BITS);
  wire [3:0]  cmd_now  = rx_next[3:0];

  // command decode on the fourth bit
  wire [3:0] map       = chan_map(cmd_now, cfg_reg[`CFG_PDIFF_BIT]);
  wire       is_chan   = ~cmd_now[3] & map[3];
  wire       is_test   = (cmd_now == `CMD_TEST_MID) | (cmd_now == `CMD_TEST_LOW)
                       | (cmd_now == `CMD_TEST_HIGH);
  wire       is_conv   = is_chan | is_test;
  // a word is only counted, so a pause between bytes is harmless
  wire       cfg_load  = at_end & (cmd_reg == `CMD_WR_CFG);

  // input pin history
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      fs_q   <= 1'b0;
    end
    else
    begin
      sclk_q <= link.sclk;
      cs_q   <= link.cs_n;
      fs_q   <= link.frame_start_strobe;
    end
  end

  // input shifting and bit count
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      active_reg  <= 1'b0;
      fs_mode_reg <= 1'b0;
      bit_cnt_reg <= 5'd0;
      rx_reg      <= 16'h0000;
      cmd_reg     <= 4'h0;
    end
    else if (start)
    begin
      active_reg  <= 1'b1;
      fs_mode_reg <= start_fs;
      bit_cnt_reg <= 5'd0;
      rx_reg      <= 16'h0000;
    end
    else if (link.cs_n)
      active_reg <= 1'b0;
    else if (cap_edge)
    begin
      rx_reg      <= rx_next;
      bit_cnt_reg <= cnt_next;
      if (at_cmd)
        cmd_reg <= cmd_now;
    end
  end

  // output word and pin; the upper nibble of a config read is filler
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_word_reg <= 16'h0000;
      link.sdo     <= 1'b0;
      link.sdo_oe  <= 1'b0;
    end
    else if (start)
    begin
      out_word_reg <= {result_reg, 6'h00};
      link.sdo     <= result_reg[9];
      link.sdo_oe  <= 1'b1;
    end
    else if (link.cs_n)
      link.sdo_oe <= 1'b0;
    else if (at_cmd && (cmd_now == `CMD_RD_CFG))
      out_word_reg[11:0] <= cfg_reg;
    else if (sh_edge)
    begin
      if (bit_cnt_reg == `WORD_BITS)
        link.sdo_oe <= 1'b0;
      else
        link.sdo <= out_word_reg[4'hf - bit_cnt_reg[3:0]];
    end
  end

  // configuration word, untouched by power-down
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cfg_reg <= `CFG_RESET;
    else if (cfg_load)
      cfg_reg <= rx_next[11:0];
  end

  // latest result in the selected coding
  always_ff @(posedge clk)
  begin
    if (!nrst)
      result_reg <= 10'h000;
    else if (raw_valid)
      result_reg <= code_result(raw_result, cfg_reg[`CFG_CODE_BIT]);
  end

  // command strobes and selection; reserved code falls through untouched
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      conv_start     <= 1'b0;
      fifo_read      <= 1'b0;
      analog_sel     <= SEL_CHANNEL;
      channel        <= 3'd0;
      sw_power_down  <= 1'b0;
      command_nibble <= 4'h0;
    end
    else
    begin
      conv_start <= at_cmd & is_conv;
      fifo_read  <= at_cmd & (cmd_now == `CMD_FIFO_RD);
      if (start)
        sw_power_down <= 1'b0;
      if (at_cmd)
      begin
        command_nibble <= cmd_now;
        if (cmd_now == `CMD_PWDN)
          sw_power_down <= 1'b1;
        if (is_chan)
        begin
          analog_sel <= SEL_CHANNEL;
          channel    <= map[2:0];
        end
        else if (cmd_now == `CMD_TEST_MID)
          analog_sel <= SEL_TEST_MID;
        else if (cmd_now == `CMD_TEST_LOW)
          analog_sel <= SEL_TEST_LOW;
        else if (cmd_now == `CMD_TEST_HIGH)
          analog_sel <= SEL_TEST_HIGH;
      end
    end
  end

  // conversion clock, one tick per serial rise or every second one
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      div_ph_reg <= 1'b0;
      conv_tick  <= 1'b0;
    end
    else
    begin
      conv_tick <= sclk_rise & (~cfg_reg[`CFG_CDIV_BIT] | div_ph_reg);
      if (sclk_rise)
        div_ph_reg <= ~div_ph_reg;
    end
  end

  // decoded fields, one clock behind the word
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      configuration_word <= `CFG_RESET;
      ref_internal       <= 1'b0;
      twos_comp          <= 1'b0;
      sample_clocks      <= `SAMPLE_SHORT;
      pseudo_diff        <= 1'b0;
      conv_mode          <= `MODE_ONE_SHOT;
      sweep_seq          <= 2'b00;
      sweep_enable       <= 1'b0;
      status_is_eoc      <= 1'b0;
      fifo_level         <= 3'd7;
    end
    else
    begin
      configuration_word <= cfg_reg;
      ref_internal       <= cfg_reg[`CFG_REF_BIT];
      twos_comp          <= cfg_reg[`CFG_CODE_BIT];
      sample_clocks      <= cfg_reg[`CFG_SAMP_BIT] ? `SAMPLE_LONG : `SAMPLE_SHORT;
      pseudo_diff        <= cfg_reg[`CFG_PDIFF_BIT];
      conv_mode          <= cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO];
      sweep_enable       <= cfg_reg[`CFG_MODE_HI];
      sweep_seq          <= cfg_reg[`CFG_MODE_HI] ? cfg_reg[`CFG_SEQ_HI:`CFG_SEQ_LO]
                                                  : 2'b00;
      status_is_eoc      <= cfg_reg[`CFG_PIN_BIT];
      fifo_level         <= trig_level(cfg_reg[`CFG_TRIG_HI:`CFG_TRIG_LO]);
    end
  end

endmodule

// [rtl/adc_cmd_host.sv]
// Purpose: host end, shifts command words out and collects the answer
// Assumes: serial clock made here from clk by a half-period divider
// Notes: serial clock idles low; one word in flight at a time
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_cmd_host
  import adc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial link
  adc_link_if.host         link,
  // user side
  input  wire logic        use_fs,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  output logic             cmd_ready,
  output logic             cmd_refused,
  output logic             rsp_valid,
  output logic      [11:0] rsp_config,
  output logic      [9:0]  rsp_result,
  output logic             init_done
);

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SYNC, H_CLOCK, H_END} host_state_e;

  localparam int HALF = `SCLK_HALF_CYCLES;

  host_state_e state_reg;
  logic [7:0]  div_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [4:0]  n_reg;
  logic        fs_mode_reg;
  logic [1:0]  mode_shadow_reg;

  wire tick     = (div_reg == 8'(HALF - 1));
  wire sclk_new = ~link.sclk;
  // capture on rise for select framing, on fall for frame framing
  wire cap      = fs_mode_reg ? ~sclk_new : sclk_new;
  wire rd_bad   = (cmd_word[15:12] == `CMD_RD_CFG)
                & (mode_shadow_reg != `MODE_ONE_SHOT);

  // half-period divider
  always_ff @(posedge clk)
  begin
    if (!nrst || state_reg == H_IDLE || tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // transfer sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg               <= H_IDLE;
      link.cs_n               <= 1'b1;
      link.sclk               <= 1'b0;
      link.sdi                <= 1'b0;
      link.frame_start_strobe <= 1'b1;
      tx_reg                  <= 16'h0000;
      rx_reg                  <= 16'h0000;
      n_reg                   <= 5'd0;
      fs_mode_reg             <= 1'b0;
      mode_shadow_reg         <= `MODE_ONE_SHOT;
      cmd_ready               <= 1'b0;
      cmd_refused             <= 1'b0;
      rsp_valid               <= 1'b0;
      rsp_config              <= 12'h000;
      rsp_result              <= 10'h000;
      init_done               <= 1'b0;
    end
    else
    begin
      cmd_refused <= 1'b0;
      rsp_valid   <= 1'b0;
      unique case (state_reg)
        H_IDLE:
        begin
          link.frame_start_strobe <= ~use_fs;
          if (!init_done)
          begin
            tx_reg      <= `INIT_WORD;
            fs_mode_reg <= use_fs;
            state_reg   <= H_SETUP;
          end
          else if (cmd_valid && cmd_ready && rd_bad)
            cmd_refused <= 1'b1;
          else if (cmd_valid && cmd_ready)
          begin
            cmd_ready   <= 1'b0;
            tx_reg      <= cmd_word;
            fs_mode_reg <= use_fs;
            if (cmd_word[15:12] == `CMD_WR_CFG)
              mode_shadow_reg <= cmd_word[`CFG_MODE_HI:`CFG_MODE_LO];
            state_reg <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          link.cs_n <= 1'b0;
          link.sdi  <= tx_reg[15];
          n_reg     <= 5'd0;
          if (tick)
          begin
            // strobe stays high in select framing: a fall with select low would restart the word
            link.frame_start_strobe <= 1'b1;
            state_reg <= fs_mode_reg ? H_SYNC : H_CLOCK;
          end
        end
        H_SYNC:
          if (tick)
          begin
            link.frame_start_strobe <= 1'b0;
            state_reg <= H_CLOCK;
          end
        H_CLOCK:
          if (tick)
          begin
            link.sclk <= sclk_new;
            if (cap)
            begin
              rx_reg <= {rx_reg[14:0], link.sdo_line};
              n_reg  <= n_reg + 5'd1;
              if (n_reg == `WORD_BITS - 5'd1)
                state_reg <= H_END;
            end
            else if (n_reg != 5'd0)
            begin
              tx_reg   <= {tx_reg[14:0], 1'b0};
              link.sdi <= tx_reg[14];
            end
          end
        H_END:
          if (tick)
          begin
            link.sclk               <= 1'b0;
            link.cs_n               <= 1'b1;
            link.frame_start_strobe <= ~fs_mode_reg;
            rsp_valid               <= init_done;
            rsp_config              <= rx_reg[11:0];
            rsp_result              <= rx_reg[15:`RESULT_LSB];
            init_done               <= 1'b1;
            cmd_ready               <= 1'b1;
            state_reg               <= H_IDLE;
          end
      endcase
    end
  end

endmodule

// [verification/adc_serial_command_config_monitor.sv]
// Purpose: wire-level checks on the link between host end and converter end
// Assumes: one clock domain, link pins sampled on clk
// Notes: framing kind is latched at each chip-select fall from the frame strobe level
`timescale 1ns/1ps
module adc_serial_command_config_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_start_strobe,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic       cs_d_reg;
  logic       sclk_d_reg;
  logic       fs_mode_reg;
  logic [4:0] cap_cnt_reg;
  wire        cap_edge;

  // capture edge depends on framing: rise for select framing, fall for strobe framing
  assign cap_edge = fs_mode_reg ? (sclk_d_reg & ~sclk) : (~sclk_d_reg & sclk);

  // count captures per word; strobe framing keeps the strobe low before select falls
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cs_d_reg    <= 1'b1;
      sclk_d_reg  <= 1'b0;
      fs_mode_reg <= 1'b0;
      cap_cnt_reg <= 5'h00;
    end
    else
    begin
      cs_d_reg   <= cs_n;
      sclk_d_reg <= sclk;
      if (cs_d_reg && !cs_n)
      begin
        fs_mode_reg <= ~frame_start_strobe;
        cap_cnt_reg <= 5'h00;
      end
      else if (!cs_n && cap_edge)
        cap_cnt_reg <= cap_cnt_reg + 5'h01;
    end
  end

  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // the two ways a word can begin
  sequence sel_start_s;
    $fell(cs_n) && frame_start_strobe;
  endsequence
  sequence fs_start_s;
    $fell(frame_start_strobe) && !cs_n;
  endsequence

  AST_SDO_IDLE: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
    else $error("serial output driven while deselected");
  AST_SDO_DESEL: assert property ($rose(cs_n) |-> ##[1:2] !sdo_oe)
    else $error("serial output not released after select rose");
  AST_SEL_START: assert property (sel_start_s |-> ##[1:2] sdo_oe)
    else $error("select framing start did not drive output");
  AST_FS_START: assert property (fs_start_s |-> ##[1:2] sdo_oe)
    else $error("strobe framing start did not drive output");
  AST_SEL_SDI_HOLD: assert property ($rose(sclk) && !cs_n && !fs_mode_reg |-> $stable(sdi))
    else $error("input bit moved at capture rise");
  AST_FS_SDI_HOLD: assert property ($fell(sclk) && !cs_n && fs_mode_reg |-> $stable(sdi))
    else $error("input bit moved at capture fall");
  AST_SEL_LAUNCH: assert property
    ($changed(sdo) && sdo_oe && $past(sdo_oe) && !fs_mode_reg |-> !sclk)
    else $error("output bit changed outside low clock phase");
  AST_FS_LAUNCH: assert property
    ($changed(sdo) && sdo_oe && $past(sdo_oe) && fs_mode_reg |-> sclk)
    else $error("output bit changed outside high clock phase");
  AST_WORD_LEN: assert property ($rose(cs_n) |-> cap_cnt_reg == 5'h10)
    else $error("word did not carry sixteen captures");
endmodule

// [verification/adc_serial_command_config_bench.sv]
// Purpose: drives command words through the host end into the converter end
// Assumes: 50 MHz clock, inputs changed 1 ns after the rising edge
// Notes: four-input variant and clock pauses are not exercised by this host
`timescale 1ns/1ps
module adc_serial_command_config_bench;
  import adc_pkg::*;
  logic        clk;
  logic        nrst;
  logic        use_fs;
  logic        cmd_valid;
  logic [15:0] cmd_word;
  logic [9:0]  raw_result;
  logic        raw_valid;
  logic        cmd_ready, cmd_refused, rsp_valid, init_done;
  logic [11:0] rsp_config, configuration_word;
  logic [9:0]  rsp_result;
  logic        ref_internal, twos_comp, pseudo_diff, sweep_enable, status_is_eoc;
  logic [4:0]  sample_clocks;
  logic [1:0]  conv_mode, sweep_seq;
  logic [2:0]  fifo_level, channel;
  logic        conv_start, conv_tick, sw_power_down, fifo_read;
  logic [3:0]  command_nibble;
  analog_sel_e analog_sel;
  int          miscompares, total_checks, n_start, n_tick, n_fifo, i;
  logic [11:0] cfg_tab [4] = '{12'h89b, 12'h62e, 12'h351, 12'hc6c};

  adc_link_if adc_link_if_i ();

  adc_cmd_host adc_cmd_host_i (.clk(clk), .nrst(nrst), .link(adc_link_if_i), .use_fs(use_fs),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
    .cmd_refused(cmd_refused), .rsp_valid(rsp_valid), .rsp_config(rsp_config),
    .rsp_result(rsp_result), .init_done(init_done));

  adc_cmd_device adc_cmd_device_i (.clk(clk), .nrst(nrst), .link(adc_link_if_i),
    .raw_result(raw_result), .raw_valid(raw_valid), .configuration_word(configuration_word),
    .ref_internal(ref_internal), .twos_comp(twos_comp), .sample_clocks(sample_clocks),
    .pseudo_diff(pseudo_diff), .conv_mode(conv_mode), .sweep_seq(sweep_seq),
    .sweep_enable(sweep_enable), .status_is_eoc(status_is_eoc), .fifo_level(fifo_level),
    .conv_start(conv_start), .analog_sel(analog_sel), .channel(channel),
    .conv_tick(conv_tick), .sw_power_down(sw_power_down), .fifo_read(fifo_read),
    .command_nibble(command_nibble));

  adc_serial_command_config_monitor adc_serial_command_config_monitor_i (.clk(clk),
    .nrst(nrst), .cs_n(adc_link_if_i.cs_n), .sclk(adc_link_if_i.sclk),
    .sdi(adc_link_if_i.sdi), .frame_start_strobe(adc_link_if_i.frame_start_strobe),
    .sdo(adc_link_if_i.sdo), .sdo_oe(adc_link_if_i.sdo_oe));

  // clock
  always #10 clk = ~clk;

  // count one-cycle strobes of the converter end
  always @(posedge clk)
  begin
    if (conv_start === 1'b1) n_start++;
    if (conv_tick === 1'b1) n_tick++;
    if (fifo_read === 1'b1) n_fifo++;
  end

  task chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp, input string m);
    chk_word({15'h0000, got}, {15'h0000, exp}, m);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one word through the host end; waits for the answer under a bound
  task send(input logic [15:0] w, input logic fs);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n_start = 0;
    n_tick = 0;
    n_fifo = 0;
    use_fs = fs;
    cmd_word = w;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(rsp_valid, 1'b1, "answer strobe");
    repeat (2) @(posedge clk);
    #1;
  endtask

  // a converter result offered before the next reading cycle
  task push(input logic [9:0] r);
    raw_result = r;
    raw_valid = 1'b1;
    @(posedge clk);
    #1;
    raw_valid = 1'b0;
  endtask

  // every decoded field against the configuration value
  task chk_cfg(input logic [11:0] v);
    chk_word({4'h0, configuration_word}, {4'h0, v}, "config");
    chk_bit(ref_internal, v[11], "reference select");
    chk_bit(twos_comp, v[10], "coding select");
    chk_word({11'h000, sample_clocks}, v[9] ? 16'h0018 : 16'h000c, "sampling");
    chk_bit(pseudo_diff, v[7], "pseudo differential");
    chk_word({14'h0000, conv_mode}, {14'h0000, v[6:5]}, "mode");
    chk_word({14'h0000, sweep_seq}, v[6] ? {14'h0000, v[4:3]} : 16'h0000, "sweep order");
    chk_bit(sweep_enable, v[6], "sweep enable");
    chk_bit(status_is_eoc, v[2], "status pin");
    chk_word({13'h0000, fifo_level}, {13'h0000, 3'd7 - {v[1:0], 1'b0}}, "fifo level");
  endtask

  // watchdog: about 23 words of some 150 cycles fit well inside this span
  initial
  begin
    #(20 * 20000);
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    use_fs = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    raw_result = 10'h000;
    raw_valid = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk_cfg(12'h000);
    // configuration table: every mode and trigger level, both framings
    for (i = 0; i < 4; i++)
    begin
      send({4'ha, cfg_tab[i]}, i[0]);
      chk_bit(init_done, 1'b1, "init done");
      chk_cfg(cfg_tab[i]);
      if (cfg_tab[i][6:5] == 2'b00)
      begin
        send(16'h9000, i[0]);
        chk_word({4'h0, rsp_config}, {4'h0, cfg_tab[i]}, "config read");
      end
      else
      begin
        cmd_word = 16'h9000;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        chk_bit(cmd_refused, 1'b1, "read refused");
        chk_bit(cmd_ready, 1'b1, "ready kept");
        cmd_valid = 1'b0;
      end
    end
    // channels and test voltages in one-shot, pseudo-differential, binary coding
    send({4'ha, cfg_tab[0]}, 1'b0);
    for (i = 0; i < 14; i++)
    begin
      if (i < 8 || i > 10)
      begin
        push(10'h3c5 ^ i[9:0]);
        send({i[3:0], 12'h000}, i[0]);
        chk_word(n_start[15:0], (i == 2) ? 16'h0000 : 16'h0001, "start strobe");
        chk_word({6'h00, rsp_result}, {6'h00, 10'h3c5 ^ i[9:0]}, "result");
        if (i < 8 && i != 2)
        begin
          chk_word({13'h0000, channel}, i[15:0], "channel");
          chk_bit(analog_sel === SEL_CHANNEL, 1'b1, "channel select");
        end
        if (i > 10)
          chk_word({14'h0000, analog_sel}, i[15:0] - 16'h000a, "test select");
      end
    end
    // two's complement coding and halved conversion clock
    send(16'ha500, 1'b0);
    push(10'h155);
    send(16'h0000, 1'b0);
    chk_word(n_tick[15:0], 16'h0008, "ticks");
    chk_word({6'h00, rsp_result}, {6'h00, 10'h355}, "twos result");
    // power-down keeps configuration, reserved code does nothing
    send(16'h8000, 1'b1);
    chk_bit(sw_power_down, 1'b1, "power down");
    chk_word(n_start[15:0], 16'h0000, "no start");
    chk_word({4'h0, configuration_word}, 16'h0500, "config kept");
    send(16'hf123, 1'b0);
    chk_word({4'h0, configuration_word}, 16'h0500, "reserved keeps config");
    chk_word(n_start[15:0], 16'h0000, "reserved no start");
    push(10'h2aa);
    send(16'he000, 1'b1);
    chk_word(n_fifo[15:0], 16'h0001, "fifo strobe");
    chk_word({6'h00, rsp_result}, {6'h00, 10'h0aa}, "fifo result");
    chk_word({12'h000, command_nibble}, 16'h000e, "command");
    wrap_up();
  end
endmodule
